// ---- design/rak_pkg.sv ----
// Package: timing, modes, states and carrier types of the restart/teach control
package rak_pkg;

    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_HZ = 1000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;

    // Times in milliseconds, counted in 1 ms ticks
    localparam int unsigned ACK_MIN_MS = 150;
    localparam int unsigned ACK_MAX_MS = 4000;
    localparam int unsigned ACK_STUCK_MS = 30000;
    localparam int unsigned TEACH_WINDOW_MS = 60000;
    localparam int unsigned SELFTEST_MS = 100;
    localparam int unsigned SHOW_RESP_MS = 2000;

    localparam int unsigned ACK_MIN_TICKS = (ACK_MIN_MS * TICK_HZ + 999) / 1000;
    localparam int unsigned ACK_MAX_TICKS = (ACK_MAX_MS * TICK_HZ) / 1000;
    localparam int unsigned ACK_STUCK_TICKS = (ACK_STUCK_MS * TICK_HZ) / 1000;
    localparam int unsigned TEACH_WINDOW_TICKS = (TEACH_WINDOW_MS * TICK_HZ) / 1000;
    localparam int unsigned SELFTEST_TICKS = (SELFTEST_MS * TICK_HZ + 999) / 1000;
    localparam int unsigned SHOW_RESP_TICKS = (SHOW_RESP_MS * TICK_HZ + 999) / 1000;

    localparam int unsigned TICK_W = 16;
    localparam logic [7:0] RESP_TIME_CODE = 8'h0c;

    localparam logic [2:0] MODE_QUALIFIED_STOP = 3'h1;
    localparam logic [2:0] MODE_STANDARD = 3'h5;
    localparam logic [2:0] MODE_PARTIAL = 3'h6;

    typedef enum logic [5:0] {
        ST_SELFTEST = 6'h01,
        ST_SHOW_RESP = 6'h02,
        ST_LOCKED = 6'h04,
        ST_ON = 6'h08,
        ST_FAULT = 6'h10,
        ST_GATE_ERR = 6'h20
    } rak_state_type;

    typedef enum logic [2:0] {
        TS_IDLE = 3'h1,
        TS_ARMED = 3'h2,
        TS_STORE = 3'h4
    } rak_teach_type;

    // Press classification delivered by the button timer
    typedef struct packed {
        logic valid_release;
        logic short_release;
        logic long_release;
        logic stuck;
    } rak_press_type;

    // Indicator group
    typedef struct packed {
        logic red;
        logic green;
        logic yellow;
    } rak_led_type;

endpackage : rak_pkg

// ---- design/rak_press_timer.sv ----
// Module: measures a synchronised button press and classifies its release
`timescale 1ns/1ns
module rak_press_timer
    import rak_pkg::*;
#(
    parameter int unsigned MIN_TICKS = ACK_MIN_TICKS,
    parameter int unsigned MAX_TICKS = ACK_MAX_TICKS,
    parameter int unsigned STUCK_TICKS = ACK_STUCK_TICKS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic pressed,
    output rak_press_type press
);
    logic [TICK_W-1:0] cnt_reg, cnt_next;
    logic prev_reg, prev_next;
    rak_press_type press_reg, press_next;

    always_comb begin
        cnt_next = cnt_reg;
        prev_next = pressed;
        press_next = '0;
        if (pressed) begin
            if (!prev_reg) begin
                cnt_next = '0;
            end else if (tick && cnt_reg != TICK_W'(STUCK_TICKS)) begin
                cnt_next = cnt_reg + 1'b1;
                // Pulse once at the stuck limit; never on the first cycle,
                // where cnt_reg still holds the length of the previous press
                if (cnt_reg == TICK_W'(STUCK_TICKS - 1)) begin
                    press_next.stuck = 1'b1;
                end
            end
        end else if (prev_reg) begin
            if (cnt_reg < TICK_W'(MIN_TICKS)) begin
                press_next.short_release = 1'b1;
            end else if (cnt_reg < TICK_W'(MAX_TICKS)) begin
                press_next.valid_release = 1'b1;
            end else begin
                press_next.long_release = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
            prev_reg <= 1'b0;
            press_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            prev_reg <= prev_next;
            press_reg <= press_next;
        end
    end

    assign press = press_reg;

endmodule : rak_press_timer

// ---- design/rak_restart_ctrl.sv ----
// Module: restart interlock, gating restart/override and blanking teach control
`timescale 1ns/1ns
module rak_restart_ctrl
    import rak_pkg::*;
#(
    parameter int unsigned BEAMS = 16,
    parameter int unsigned TEACH_TICKS = TEACH_WINDOW_TICKS,
    parameter int unsigned STUCK_TICKS = ACK_STUCK_TICKS,
    parameter int unsigned TICK_CYCLES = TICK_DIV
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [2:0] OPERATING_MODE,
    input wire logic COMBINED_RESET_IO_PIN_IN,
    input wire logic CONTROL_INPUT_THREE,
    input wire logic CONTROL_INPUT_FOUR,
    input wire logic CONTROL_INPUT_EIGHT,
    input wire logic [BEAMS-1:0] BEAM_BLOCKED,
    input wire logic SYNC_BEAMS_OCCUPIED,
    input wire logic GATING_ERROR,
    input wire logic SELFTEST_PASS,
    output logic COMBINED_RESET_IO_PIN_OUT,
    output logic COMBINED_RESET_IO_PIN_OE_N,
    output logic SAFETY_SWITCH_OUT_A,
    output logic SAFETY_SWITCH_OUT_B,
    output logic LED_RED,
    output logic LED_GREEN,
    output logic READY_INDICATOR,
    output logic [7:0] DISPLAY_CODE,
    output logic GATING_RESTART_PULSE,
    output logic OVERRIDE_PULSE,
    output logic BLANKING_ENABLE,
    output logic [BEAMS-1:0] BLANKING_MASK,
    output logic TEACH_ACTIVE
);
    // Two-stage synchronisers for every pin input except OPERATING_MODE
    logic [3:0] sync1_reg, sync2_reg;
    logic [BEAMS-1:0] beam1_reg, beam2_reg;
    logic [2:0] misc1_reg, misc2_reg;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            beam1_reg <= '0;
            beam2_reg <= '0;
            misc1_reg <= '0;
            misc2_reg <= '0;
        end else begin
            sync1_reg <= {CONTROL_INPUT_EIGHT, CONTROL_INPUT_FOUR, CONTROL_INPUT_THREE,
                          COMBINED_RESET_IO_PIN_IN};
            sync2_reg <= sync1_reg;
            beam1_reg <= BEAM_BLOCKED;
            beam2_reg <= beam1_reg;
            misc1_reg <= {SELFTEST_PASS, GATING_ERROR, SYNC_BEAMS_OCCUPIED};
            misc2_reg <= misc1_reg;
        end
    end

    logic rst_pin, in3, in4, in8, sync_occ, gate_err, st_pass;
    assign rst_pin = sync2_reg[0];
    assign in3 = sync2_reg[1];
    assign in4 = sync2_reg[2];
    assign in8 = sync2_reg[3];
    assign sync_occ = misc2_reg[0];
    assign gate_err = misc2_reg[1];
    assign st_pass = misc2_reg[2];

    logic field_clear;
    assign field_clear = ~|beam2_reg;

    // Pin routing per operating mode: which input carries the switching and
    // timer hold signals, and which one is bridged to the reset pin
    logic gate_switch, timer_hold_signal, bridge_in, mode_needs_th;
    always_comb begin
        unique case (OPERATING_MODE)
            MODE_QUALIFIED_STOP: begin
                gate_switch = in3;
                timer_hold_signal = in4;
                bridge_in = in8;
            end
            MODE_PARTIAL: begin
                gate_switch = in4;
                timer_hold_signal = in8;
                bridge_in = in3;
            end
            default: begin
                gate_switch = in3;
                timer_hold_signal = in8;
                bridge_in = in4;
            end
        endcase
    end
    assign mode_needs_th = (OPERATING_MODE == MODE_QUALIFIED_STOP) ||
                           (OPERATING_MODE == MODE_PARTIAL);

    // Bridge opened with pin high and bridged input low means teach key actuated
    logic teach_key, ack_pressed;
    assign teach_key = rst_pin && !bridge_in;
    assign ack_pressed = rst_pin && bridge_in;

    // 1 ms tick divider
    logic [15:0] div_reg, div_next;
    logic tick_reg, tick_next;
    always_comb begin
        tick_next = 1'b0;
        div_next = div_reg + 1'b1;
        if (div_reg == 16'(TICK_CYCLES - 1)) begin
            div_next = '0;
            tick_next = 1'b1;
        end
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    rak_press_type ack, key;
    rak_press_timer #(.STUCK_TICKS(STUCK_TICKS)) u_ack_timer (
        .clk(CLK),
        .reset_n(RESET_N),
        .tick(tick_reg),
        .pressed(ack_pressed),
        .press(ack)
    );
    // Teach key timing only needs a release pulse; long presses still count
    rak_press_timer #(.MIN_TICKS(0), .MAX_TICKS(STUCK_TICKS), .STUCK_TICKS(STUCK_TICKS))
    u_key_timer (
        .clk(CLK),
        .reset_n(RESET_N),
        .tick(tick_reg),
        .pressed(teach_key),
        .press(key)
    );
    logic key_release;
    assign key_release = key.valid_release | key.long_release | key.short_release;

    // Main interlock state machine
    rak_state_type state_reg, state_next;
    logic [TICK_W-1:0] st_cnt_reg, st_cnt_next;
    logic grs_next, ovr_next, grs_reg, ovr_reg;
    logic manual_ok;

    assign manual_ok = gate_switch && (!mode_needs_th || !timer_hold_signal);

    always_comb begin
        state_next = state_reg;
        st_cnt_next = st_cnt_reg;
        grs_next = 1'b0;
        ovr_next = 1'b0;
        if (tick_reg) begin
            st_cnt_next = st_cnt_reg + 1'b1;
        end
        unique case (state_reg)
            ST_SELFTEST: begin
                if (st_pass && st_cnt_reg >= TICK_W'(SELFTEST_TICKS)) begin
                    state_next = ST_SHOW_RESP;
                    st_cnt_next = '0;
                end
            end
            ST_SHOW_RESP: begin
                if (st_cnt_reg >= TICK_W'(SHOW_RESP_TICKS)) begin
                    state_next = ST_LOCKED;
                end
            end
            ST_LOCKED: begin
                // Short and long releases fall through and leave the lock alone
                if (ack.stuck) begin
                    state_next = ST_FAULT;
                end else if (ack.valid_release && field_clear) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (gate_err) begin
                    state_next = ST_GATE_ERR;
                end else if (!field_clear) begin
                    state_next = ST_LOCKED;
                end
            end
            ST_GATE_ERR: begin
                if (ack.stuck) begin
                    state_next = ST_FAULT;
                end else if (ack.valid_release && manual_ok) begin
                    grs_next = !sync_occ;
                    ovr_next = sync_occ;
                    state_next = ST_ON;
                end
            end
            ST_FAULT: begin
                // Only a power cycle leaves the fault interlock
                state_next = ST_FAULT;
            end
            default: state_next = ST_LOCKED;
        endcase
    end

    // Teach sequencer
    rak_teach_type teach_reg, teach_next;
    logic [TICK_W-1:0] tw_cnt_reg, tw_cnt_next;
    logic blank_en_reg, blank_en_next;
    logic [BEAMS-1:0] mask_reg, mask_next;

    always_comb begin
        teach_next = teach_reg;
        tw_cnt_next = tw_cnt_reg;
        blank_en_next = blank_en_reg;
        mask_next = mask_reg;
        unique case (teach_reg)
            TS_IDLE: begin
                if (key_release) begin
                    teach_next = TS_ARMED;
                    tw_cnt_next = '0;
                end
            end
            TS_ARMED: begin
                if (tick_reg) begin
                    tw_cnt_next = tw_cnt_reg + 1'b1;
                end
                if (key_release) begin
                    teach_next = TS_STORE;
                end else if (tw_cnt_reg > TICK_W'(TEACH_TICKS)) begin
                    teach_next = TS_IDLE;
                end
            end
            TS_STORE: begin
                // Old pattern is replaced wholesale; a clear field disables blanking
                mask_next = beam2_reg;
                blank_en_next = !field_clear;
                teach_next = TS_IDLE;
            end
            default: teach_next = TS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= ST_SELFTEST;
            st_cnt_reg <= '0;
            grs_reg <= 1'b0;
            ovr_reg <= 1'b0;
            teach_reg <= TS_IDLE;
            tw_cnt_reg <= '0;
            blank_en_reg <= 1'b0;
            mask_reg <= '0;
        end else begin
            state_reg <= state_next;
            st_cnt_reg <= st_cnt_next;
            grs_reg <= grs_next;
            ovr_reg <= ovr_next;
            teach_reg <= teach_next;
            tw_cnt_reg <= tw_cnt_next;
            blank_en_reg <= blank_en_next;
            mask_reg <= mask_next;
        end
    end

    // Registered outputs
    rak_led_type led_reg, led_next;
    logic ossd_reg, ossd_next;
    logic [7:0] disp_reg, disp_next;
    logic teach_act_reg, teach_act_next;
    always_comb begin
        teach_act_next = (teach_next != TS_IDLE);
        ossd_next = (state_next == ST_ON);
        led_next.red = !ossd_next && (state_next != ST_SELFTEST);
        led_next.green = ossd_next;
        led_next.yellow = field_clear && (state_next == ST_LOCKED);
        disp_next = (state_next == ST_SHOW_RESP) ? RESP_TIME_CODE : 8'h00;
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            led_reg <= '0;
            ossd_reg <= 1'b0;
            disp_reg <= 8'h00;
            teach_act_reg <= 1'b0;
        end else begin
            led_reg <= led_next;
            ossd_reg <= ossd_next;
            disp_reg <= disp_next;
            teach_act_reg <= teach_act_next;
        end
    end

    // Reset pin is only read here; driving it is left released
    logic oe_n_reg;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= 1'b1;
        end
    end

    assign COMBINED_RESET_IO_PIN_OUT = 1'b0;
    assign COMBINED_RESET_IO_PIN_OE_N = oe_n_reg;
    assign SAFETY_SWITCH_OUT_A = ossd_reg;
    assign SAFETY_SWITCH_OUT_B = ossd_reg;
    assign LED_RED = led_reg.red;
    assign LED_GREEN = led_reg.green;
    assign READY_INDICATOR = led_reg.yellow;
    assign DISPLAY_CODE = disp_reg;
    assign GATING_RESTART_PULSE = grs_reg;
    assign OVERRIDE_PULSE = ovr_reg;
    assign BLANKING_ENABLE = blank_en_reg;
    assign BLANKING_MASK = mask_reg;
    assign TEACH_ACTIVE = teach_act_reg;

endmodule : rak_restart_ctrl

// ---- testbench/rak_restart_checker.sv ----
// Checker: port-level properties of the restart and teach control
`timescale 1ns/1ns
module rak_restart_checker
    import rak_pkg::*;
#(
    parameter int unsigned BEAMS = 16
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [2:0] OPERATING_MODE,
    input wire logic COMBINED_RESET_IO_PIN_IN,
    input wire logic CONTROL_INPUT_THREE,
    input wire logic CONTROL_INPUT_FOUR,
    input wire logic CONTROL_INPUT_EIGHT,
    input wire logic SYNC_BEAMS_OCCUPIED,
    input wire logic SAFETY_SWITCH_OUT_A,
    input wire logic SAFETY_SWITCH_OUT_B,
    input wire logic LED_RED,
    input wire logic LED_GREEN,
    input wire logic READY_INDICATOR,
    input wire logic [7:0] DISPLAY_CODE,
    input wire logic GATING_RESTART_PULSE,
    input wire logic OVERRIDE_PULSE,
    input wire logic BLANKING_ENABLE,
    input wire logic [BEAMS-1:0] BLANKING_MASK
);
    logic sw;
    logic hold;
    logic need_hold;
    logic pulse;
    // Switch and hold sit on different pins in each mode
    assign sw = (OPERATING_MODE == MODE_PARTIAL) ? CONTROL_INPUT_FOUR : CONTROL_INPUT_THREE;
    assign hold = (OPERATING_MODE == MODE_QUALIFIED_STOP) ? CONTROL_INPUT_FOUR : CONTROL_INPUT_EIGHT;
    assign need_hold = (OPERATING_MODE == MODE_QUALIFIED_STOP) || (OPERATING_MODE == MODE_PARTIAL);
    assign pulse = GATING_RESTART_PULSE || OVERRIDE_PULSE;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    chk_red_on: assert property (SAFETY_SWITCH_OUT_A |-> !LED_RED && LED_GREEN)
        else $error("red lit while outputs on");
    chk_out_pair: assert property (SAFETY_SWITCH_OUT_A == SAFETY_SWITCH_OUT_B)
        else $error("switch outputs differ");
    chk_ready_locked: assert property (READY_INDICATOR |-> LED_RED && !SAFETY_SWITCH_OUT_A)
        else $error("ready while not locked");
    chk_on_release: assert property (COMBINED_RESET_IO_PIN_IN [*8] |-> !$rose(SAFETY_SWITCH_OUT_A))
        else $error("on state before release");
    chk_resp_show: assert property (DISPLAY_CODE != 8'h00 |-> DISPLAY_CODE == RESP_TIME_CODE)
        else $error("bad display code");
    chk_start_off: assert property ($rose(RESET_N) |-> (!SAFETY_SWITCH_OUT_A) [*8])
        else $error("outputs on during start");
    chk_pulse_switch: assert property (pulse |-> $past(sw, 6))
        else $error("manual gating without switch");
    chk_pulse_hold: assert property (pulse && need_hold |-> !$past(hold, 6))
        else $error("manual gating without timer hold");
    chk_restart_sel: assert property (GATING_RESTART_PULSE |-> !$past(SYNC_BEAMS_OCCUPIED, 6))
        else $error("restart with sync beams occupied");
    chk_override_sel: assert property (OVERRIDE_PULSE |-> $past(SYNC_BEAMS_OCCUPIED, 6))
        else $error("override with sync beams free");
    chk_pulse_on: assert property (pulse |-> ##[0:3] SAFETY_SWITCH_OUT_A)
        else $error("no on state after manual gating");
    chk_blank_mask: assert property (BLANKING_ENABLE |-> BLANKING_MASK != '0)
        else $error("blanking with empty mask");
    cover property ($rose(SAFETY_SWITCH_OUT_A));
    cover property (GATING_RESTART_PULSE);
    cover property (OVERRIDE_PULSE);
    cover property ($rose(BLANKING_ENABLE));
endmodule : rak_restart_checker

bind rak_restart_ctrl rak_restart_checker #(.BEAMS(BEAMS)) i_rak_restart_checker (
    .CLK, .RESET_N, .OPERATING_MODE, .COMBINED_RESET_IO_PIN_IN, .CONTROL_INPUT_THREE,
    .CONTROL_INPUT_FOUR, .CONTROL_INPUT_EIGHT, .SYNC_BEAMS_OCCUPIED, .SAFETY_SWITCH_OUT_A,
    .SAFETY_SWITCH_OUT_B, .LED_RED, .LED_GREEN, .READY_INDICATOR, .DISPLAY_CODE,
    .GATING_RESTART_PULSE, .OVERRIDE_PULSE, .BLANKING_ENABLE, .BLANKING_MASK
);

// ---- testbench/rak_operator_model.sv ----
// Partner: buttons, teach key and machine control wired per operating mode
`timescale 1ns/1ns
module rak_operator_model
    import rak_pkg::*;
(
    input wire logic [2:0] mode,
    input wire logic ack,
    input wire logic key,
    input wire logic cs,
    input wire logic th,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin,
    output logic in3,
    output logic in4,
    output logic in8
);
    logic bridge;
    always_comb begin
        // Acknowledge button and teach key share this pin; the device may also drive it
        pin = ack | key | (!pin_oe_n & pin_out);
        // Teach key opens the bridge and pulls the bridged input low
        bridge = ack & !key;
        case (mode)
            MODE_QUALIFIED_STOP: begin
                in3 = cs;
                in4 = th;
                in8 = bridge;
            end
            MODE_PARTIAL: begin
                in3 = bridge;
                in4 = cs;
                in8 = th;
            end
            default: begin
                in3 = cs;
                in4 = bridge;
                in8 = th;
            end
        endcase
    end
endmodule : rak_operator_model

// ---- testbench/rak_restart_ctrl_tb.sv ----
// Testbench: operator sequences against the restart and teach control
`timescale 1ns/1ns
module rak_restart_ctrl_tb;
    import rak_pkg::*;
    localparam int MS = 2;
    localparam int P = 160;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic [2:0] mode = MODE_STANDARD;
    logic ack = 1'b0;
    logic key = 1'b0;
    logic cs = 1'b0;
    logic th = 1'b0;
    logic [15:0] beams = 16'h0000;
    logic sync = 1'b0;
    logic gerr = 1'b0;
    logic pass = 1'b0;
    logic pin, in3, in4, in8, p_out, oe_n, sw_a, sw_b, red, green, ready, gr_p, ov_p, b_en, teach;
    logic showing;
    logic [7:0] disp;
    logic [15:0] mask;
    logic [15:0] rnd = 16'hb875;
    logic [2:0] modes [3] = '{MODE_STANDARD, MODE_QUALIFIED_STOP, MODE_PARTIAL};
    int fail_count = 0;
    int num_checks = 0;
    int st = 0;
    int q[$];

    always #25 CLK = ~CLK;
    always_comb showing = (disp == RESP_TIME_CODE);

    rak_operator_model i_rak_operator_model (.mode(mode), .ack(ack), .key(key), .cs(cs),
        .th(th), .pin_out(p_out), .pin_oe_n(oe_n), .pin(pin), .in3(in3), .in4(in4), .in8(in8));

    // A 2-cycle tick and a short teach window keep the run near 30k cycles
    rak_restart_ctrl #(.BEAMS(16), .TEACH_TICKS(400), .STUCK_TICKS(4500), .TICK_CYCLES(MS))
    i_rak_restart_ctrl (
        .CLK(CLK), .RESET_N(RESET_N), .OPERATING_MODE(mode), .COMBINED_RESET_IO_PIN_IN(pin),
        .CONTROL_INPUT_THREE(in3), .CONTROL_INPUT_FOUR(in4), .CONTROL_INPUT_EIGHT(in8),
        .BEAM_BLOCKED(beams), .SYNC_BEAMS_OCCUPIED(sync), .GATING_ERROR(gerr),
        .SELFTEST_PASS(pass), .COMBINED_RESET_IO_PIN_OUT(p_out),
        .COMBINED_RESET_IO_PIN_OE_N(oe_n), .SAFETY_SWITCH_OUT_A(sw_a),
        .SAFETY_SWITCH_OUT_B(sw_b), .LED_RED(red), .LED_GREEN(green),
        .READY_INDICATOR(ready), .DISPLAY_CODE(disp), .GATING_RESTART_PULSE(gr_p),
        .OVERRIDE_PULSE(ov_p), .BLANKING_ENABLE(b_en), .BLANKING_MASK(mask),
        .TEACH_ACTIVE(teach));

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask : cyc

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Model states: 0 locked, 1 on, 2 gating error, 3 fault
    task automatic cmp_state(input string nm);
        logic e;
        e = (st == 1);
        chk("switch outputs", {14'h0, e, e}, {14'h0, sw_a, sw_b});
        chk("red green", {14'h0, !e, e}, {14'h0, red, green});
        chk("ready", {15'h0, st == 0 && beams == 16'h0}, {15'h0, ready});
        $display("test %s done", nm);
    endtask : cmp_state

    task automatic wait_on(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        chk("wait flag", 16'h1, {15'h0, s});
    endtask : wait_on

    task automatic press(input bit k, input int ms);
        if (k) key = 1'b1;
        else ack = 1'b1;
        cyc(ms * MS);
        ack = 1'b0;
        key = 1'b0;
        cyc(20);
    endtask : press

    task automatic gate_err();
        gerr = 1'b1;
        cyc(5);
        gerr = 1'b0;
        cyc(10);
        st = 2;
    endtask : gate_err

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // Every manual gating pulse must match the next queued kind
    always @(posedge CLK) begin
        if (gr_p === 1'b1 || ov_p === 1'b1) begin
            chk("pulse kind", 16'((q.size() > 0) ? q.pop_front() : 0), {14'h0, ov_p, gr_p});
        end
    end

    initial begin
        cyc(8);
        RESET_N = 1'b1;
        pass = 1'b1;
        wait_on(showing, 1000);
        chk("outputs in start", 16'h0, {15'h0, sw_a});
        chk("pin drive", 16'h2, {14'h0, oe_n, p_out});
        wait_on(ready, 10000);
        cmp_state("start");
        press(0, 100);
        cmp_state("short press");
        press(0, P);
        st = 1;
        cmp_state("unlock");
        rnd = lfsr(rnd);
        beams = rnd;
        cyc(10);
        st = 0;
        cmp_state("field blocked");
        beams = 16'h0;
        cyc(10);
        cmp_state("field clear");
        press(0, 4100);
        cmp_state("long press");
        press(0, P);
        st = 1;
        foreach (modes[i]) begin
            mode = modes[i];
            cs = 1'b0;
            gate_err();
            cmp_state("gating error");
            press(0, P);
            cmp_state("no switch");
            cs = 1'b1;
            th = (i > 0);
            if (i > 0) begin
                press(0, P);
                cmp_state("timer hold wrong");
            end
            th = 1'b0;
            q.push_back(1);
            press(0, P);
            st = 1;
            cmp_state("gating restart");
        end
        mode = MODE_STANDARD;
        sync = 1'b1;
        gate_err();
        q.push_back(2);
        press(0, P);
        st = 1;
        cmp_state("override");
        sync = 1'b0;
        rnd = lfsr(rnd);
        beams = rnd;
        cyc(10);
        st = 0;
        press(1, P);
        chk("teach armed", 16'h1, {15'h0, teach});
        press(1, P);
        chk("blanking on", 16'h1, {15'h0, b_en});
        chk("teach done", 16'h0, {15'h0, teach});
        chk("blanking mask", rnd, mask);
        beams = 16'h0;
        press(1, P);
        press(1, P);
        chk("blanking off", 16'h0, {15'h0, b_en});
        beams = lfsr(rnd);
        press(1, P);
        cyc(450 * MS);
        press(1, P);
        chk("late accept", 16'h0, {15'h0, b_en});
        beams = 16'h0;
        press(0, 4600);
        st = 3;
        cmp_state("stuck button");
        chk("pending pulses", 16'h0, 16'(q.size()));
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge CLK);
        fail_count++;
        end_sim();
    end
endmodule : rak_restart_ctrl_tb
